// *** mam_bit_map.sv ***
`timescale 1ns/1ps
`default_nettype none

module mam_bit_map
   import mam_pkg::*;
(
   // Bit address in
   input  wire logic [7:0] bit_addr,
   // Byte location out
   output var  logic [7:0] byte_addr,
   output var  logic [2:0] bit_idx,
   output var  logic       in_sfr
);

   always_comb begin
      bit_idx = bit_addr[2:0];
      in_sfr  = bit_addr[7];
      if (bit_addr[7]) begin
         // Upper bit space lands on special function bytes ending in 0 or 8
         byte_addr = {bit_addr[7:3], 3'h0};
      end else begin
         byte_addr = MAM_BITBYTE_BASE + {4'h0, bit_addr[6:3]};
      end
   end

endmodule : mam_bit_map

`default_nettype wire

// *** mam_decoder.sv ***
// Notes on behaviour
// - Low 128 internal bytes give same storage for direct and indirect access.
// - Upper 128: indirect goes to RAM, direct goes to special function space.
// - First 32 internal bytes form four banks of working registers.
// - The 16 bytes after the banks are byte or bit addressable.
// - On-chip 4k data block repeats on every 4k across 64k space when steering is all on-chip.
// - External data steering: all on-chip, all off-chip, or split at 4k.
// - Off-chip data port runs multiplexed or separate address and data lines.
// - 64k program flash, rewritable in 512-byte sectors in system, top sector at 0xFE00 locked.
// - Extra 128-byte flash sector decoded at 0x10000 to 0x1007F.
`timescale 1ns/1ps
`default_nettype none

module mam_decoder
   import mam_pkg::*;
#(
   parameter int STROBE_CYC = MAM_STROBE_CYC
)
(
   // Clock, reset, enable
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   // Core request
   input  wire logic       req_valid,
   input  wire mam_req_t   req,
   input  wire logic [1:0] reg_bank,
   // Configuration
   input  wire mam_steer_t steer,
   input  wire logic       muxed,
   // Decoded selects
   output var  logic       busy,
   output var  mam_dec_t   dec,
   output var  logic       done,
   output var  logic [7:0] rdata,
   // Off-chip data port
   output var  mam_off_t   off,
   input  wire logic [7:0] ad_in
);

   typedef enum logic [1:0] {
      MAM_ST_IDLE,
      MAM_ST_ADDR,
      MAM_ST_STROBE
   } mam_st_t;

   typedef struct packed {
      mam_st_t    st;
      logic [3:0] cnt;
      logic       busy;
      logic       wr;
      logic [7:0] wdata;
      mam_dec_t   dec;
      mam_off_t   off;
      logic       done;
      logic [7:0] rdata;
      logic [7:0] ad_s1;
      logic [7:0] ad_s2;
   } mam_state_t;

   localparam logic [3:0] CNT_LOAD = 4'(STROBE_CYC - 1);

   mam_state_t q;
   mam_state_t n;

   logic [7:0] bit_byte;
   logic [2:0] bit_idx;
   logic       bit_sfr;
   logic       take;
   logic       x_onchip;

   mam_bit_map u_bit_map (
      .bit_addr  (req.addr[7:0]),
      .byte_addr (bit_byte),
      .bit_idx   (bit_idx),
      .in_sfr    (bit_sfr)
   );

   assign take = req_valid && !q.busy;

   always_comb begin
      unique case (steer)
         MAM_STEER_ONCHIP:  x_onchip = 1'b1;
         MAM_STEER_OFFCHIP: x_onchip = 1'b0;
         MAM_STEER_SPLIT:   x_onchip = req.addr[15:0] < MAM_XRAM_TOP;
         default:           x_onchip = 1'b1;
      endcase
   end

   always_comb begin
      n = q;
      // Selects are one-cycle pulses
      n.dec.iram_sel     = 1'b0;
      n.dec.sfr_sel      = 1'b0;
      n.dec.bit_sel      = 1'b0;
      n.dec.xram_sel     = 1'b0;
      n.dec.flash_sel    = 1'b0;
      n.dec.extra_sel    = 1'b0;
      n.dec.erase_req    = 1'b0;
      n.dec.reserved_hit = 1'b0;
      n.dec.range_err    = 1'b0;
      n.done             = 1'b0;
      // Pin lines pass two flops before anyone reads them
      n.ad_s1 = ad_in;
      n.ad_s2 = q.ad_s1;

      if (take) begin
         n.dec.write = req.write;
         n.dec.wdata = req.wdata;
         unique case (req.op)
            MAM_OP_DIRECT: begin
               if (req.addr[7:0] < MAM_UPPER_BASE) begin
                  n.dec.iram_sel  = 1'b1;
                  n.dec.iram_addr = req.addr[7:0];
               end else begin
                  n.dec.sfr_sel  = 1'b1;
                  n.dec.sfr_addr = req.addr[7:0];
               end
            end
            MAM_OP_INDIRECT: begin
               // Indirect never reaches the special function space
               n.dec.iram_sel  = 1'b1;
               n.dec.iram_addr = req.addr[7:0];
            end
            MAM_OP_WREG: begin
               n.dec.iram_sel  = 1'b1;
               n.dec.iram_addr = {MAM_BANK_HI, reg_bank, req.addr[2:0]};
            end
            MAM_OP_BIT: begin
               n.dec.bit_sel = 1'b1;
               n.dec.bit_idx = bit_idx;
               if (bit_sfr) begin
                  n.dec.sfr_sel  = 1'b1;
                  n.dec.sfr_addr = bit_byte;
               end else begin
                  n.dec.iram_sel  = 1'b1;
                  n.dec.iram_addr = bit_byte;
               end
            end
            MAM_OP_XDATA: begin
               if (x_onchip) begin
                  n.dec.xram_sel  = 1'b1;
                  n.dec.xram_addr = req.addr[MAM_XRAM_AW-1:0];
               end else begin
                  n.busy           = 1'b1;
                  n.wr             = req.write;
                  n.wdata          = req.wdata;
                  n.off.addr_hi    = req.addr[15:8];
                  if (muxed) begin
                     // Low address shares the data lines, latched by ale
                     n.off.ale    = 1'b1;
                     n.off.ad_out = req.addr[7:0];
                     n.off.ad_oe  = 1'b1;
                     n.st         = MAM_ST_ADDR;
                  end else begin
                     n.off.addr_lo = req.addr[7:0];
                     n.off.rd      = !req.write;
                     n.off.wr      = req.write;
                     n.off.ad_out  = req.wdata;
                     n.off.ad_oe   = req.write;
                     n.cnt         = CNT_LOAD;
                     n.st          = MAM_ST_STROBE;
                  end
               end
            end
            MAM_OP_CODE_READ,
            MAM_OP_CODE_ERASE: begin
               if (!req.addr[16]) begin
                  n.dec.flash_sel    = req.op == MAM_OP_CODE_READ;
                  n.dec.flash_addr   = req.addr[15:0];
                  n.dec.reserved_hit = req.addr[15:0] >= MAM_FACTORY_BASE;
                  n.dec.sector       = req.addr[15:MAM_SECTOR_LSB];
                  // Factory area is guarded even if software strays into it
                  n.dec.erase_req    = req.op == MAM_OP_CODE_ERASE
                                       && req.addr[15:0] < MAM_FACTORY_BASE;
               end else if (req.addr <= MAM_EXTRA_LAST) begin
                  n.dec.extra_sel  = 1'b1;
                  n.dec.extra_addr = req.addr[6:0];
                  n.dec.erase_req  = req.op == MAM_OP_CODE_ERASE;
               end else begin
                  n.dec.range_err = 1'b1;
               end
            end
            default: begin
               n.dec.range_err = 1'b1;
            end
         endcase
      end

      unique case (q.st)
         MAM_ST_IDLE: begin
         end
         MAM_ST_ADDR: begin
            n.off.ale    = 1'b0;
            n.off.rd     = !q.wr;
            n.off.wr     = q.wr;
            n.off.ad_out = q.wdata;
            n.off.ad_oe  = q.wr;
            n.cnt        = CNT_LOAD;
            n.st         = MAM_ST_STROBE;
         end
         MAM_ST_STROBE: begin
            if (q.cnt == 4'h0) begin
               // Strobe covers the synchroniser delay on read data
               n.rdata     = q.ad_s2;
               n.off.rd    = 1'b0;
               n.off.wr    = 1'b0;
               n.off.ad_oe = 1'b0;
               n.done      = 1'b1;
               n.busy      = 1'b0;
               n.st        = MAM_ST_IDLE;
            end else begin
               n.cnt = q.cnt - 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         q <= '0;
      end else if (clk_en) begin
         q <= n;
      end
   end

   assign busy  = q.busy;
   assign dec   = q.dec;
   assign done  = q.done;
   assign rdata = q.rdata;
   assign off   = q.off;

endmodule : mam_decoder

`default_nettype wire

// *** mam_decoder_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module mam_decoder_props
   import mam_pkg::*;
#(
   parameter int STROBE_CYC = MAM_STROBE_CYC
)
(
   // Watched ports
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       clk_en,
   input wire logic       req_valid,
   input wire mam_req_t   req,
   input wire logic [1:0] reg_bank,
   input wire mam_steer_t steer,
   input wire logic       muxed,
   input wire logic       busy,
   input wire mam_dec_t   dec,
   input wire logic       done,
   input wire mam_off_t   off
);
   logic tk;
   logic xon;
   assign tk = clk_en && req_valid && !busy;
   assign xon = steer == MAM_STEER_ONCHIP || (steer == MAM_STEER_SPLIT && req.addr[15:12] == 4'h0);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   chk_low_same: assert property (tk && req.op inside {MAM_OP_DIRECT, MAM_OP_INDIRECT} && !req.addr[7]
      |=> dec.iram_sel && dec.iram_addr == $past(req.addr[7:0])) else $error("low map");
   chk_upper_split: assert property (tk && req.op inside {MAM_OP_DIRECT, MAM_OP_INDIRECT} && req.addr[7]
      |=> dec.sfr_sel == ($past(req.op) == MAM_OP_DIRECT) && dec.iram_sel != dec.sfr_sel) else $error("upper map");
   chk_wreg_bank: assert property (tk && req.op == MAM_OP_WREG
      |=> dec.iram_addr == {3'h0, $past(reg_bank), $past(req.addr[2:0])}) else $error("bank");
   chk_bit_area: assert property (tk && req.op == MAM_OP_BIT && !req.addr[7]
      |=> dec.iram_addr == 8'h20 + $past(req.addr[6:3]) && dec.bit_idx == $past(req.addr[2:0])) else $error("bit");
   chk_xram_alias: assert property (tk && req.op == MAM_OP_XDATA && xon
      |=> dec.xram_sel && !busy && dec.xram_addr == $past(req.addr[11:0])) else $error("alias");
   chk_off_timing: assert property (tk && req.op == MAM_OP_XDATA && !xon && !muxed
      |-> ##1 busy && !dec.xram_sel ##STROBE_CYC done && !busy) else $error("offchip");
   chk_mux_ale: assert property (tk && req.op == MAM_OP_XDATA && !xon && muxed
      |=> off.ale && off.ad_oe && off.ad_out == $past(req.addr[7:0]) ##1 !off.ale) else $error("ale");
   chk_sector_erase: assert property (tk && req.op == MAM_OP_CODE_ERASE && req.addr < 17'h0FE00
      |=> dec.erase_req && dec.sector == $past(req.addr[15:9])) else $error("erase");
   chk_factory_lock: assert property (tk && req.op == MAM_OP_CODE_ERASE && req.addr[16:9] == 8'h7F
      |=> dec.reserved_hit && !dec.erase_req) else $error("factory");
   chk_extra_sect: assert property (tk && req.op == MAM_OP_CODE_READ && req.addr[16:7] == 10'h200
      |=> dec.extra_sel && !dec.flash_sel && dec.extra_addr == $past(req.addr[6:0])) else $error("extra");
   cov_off: cover property (done);
   cov_range: cover property (dec.range_err);
   cov_alias: cover property (dec.xram_sel);
   cov_write: cover property (off.wr && off.ad_oe);
endmodule : mam_decoder_props
bind mam_decoder mam_decoder_props #(.STROBE_CYC(STROBE_CYC)) i_mam_decoder_props (.mclk, .sys_rst, .clk_en,
   .req_valid, .req, .reg_bank, .steer, .muxed, .busy, .dec, .done, .off);
`default_nettype wire

// *** mam_offchip_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module mam_offchip_mem
   import mam_pkg::*;
(
   // Port from the block
   input  wire logic       mclk,
   input  wire mam_off_t   off,
   input  wire logic       muxed,
   // Shared data lines back
   output var  logic [7:0] ad_in
);
   logic [7:0] lat_q;
   always_ff @(posedge mclk) begin
      if (off.ale) lat_q <= off.ad_out;
      // Released lines show the inverse, so a stale sample is caught
      ad_in <= off.rd ? ((muxed ? lat_q : off.addr_lo) ^ off.addr_hi ^ 8'h5A) : ~ad_in;
   end
endmodule : mam_offchip_mem
`default_nettype wire

// *** mam_pkg.sv ***
package mam_pkg;

   // Internal data space layout
   localparam logic [7:0]  MAM_UPPER_BASE   = 8'h80;
   localparam logic [7:0]  MAM_BITBYTE_BASE = 8'h20;
   localparam logic [2:0]  MAM_BANK_HI      = 3'h0;

   // External data space layout
   localparam int          MAM_XRAM_AW      = 12;
   localparam logic [15:0] MAM_XRAM_TOP     = 16'h1000;

   // Program flash layout
   localparam int          MAM_SECTOR_LSB   = 9;
   localparam logic [15:0] MAM_FACTORY_BASE = 16'hFE00;
   localparam logic [16:0] MAM_EXTRA_BASE   = 17'h10000;
   localparam logic [16:0] MAM_EXTRA_LAST   = 17'h1007F;

   // Off-chip strobe timing
   localparam int          MAM_CLK_MHZ      = 125;
   localparam int          MAM_STROBE_NS    = 40;
   localparam int          MAM_STROBE_CYC   = (MAM_STROBE_NS * MAM_CLK_MHZ + 999) / 1000;

   typedef enum logic [2:0] {
      MAM_OP_DIRECT,
      MAM_OP_INDIRECT,
      MAM_OP_WREG,
      MAM_OP_BIT,
      MAM_OP_XDATA,
      MAM_OP_CODE_READ,
      MAM_OP_CODE_ERASE
   } mam_op_t;

   typedef enum logic [1:0] {
      MAM_STEER_ONCHIP,
      MAM_STEER_OFFCHIP,
      MAM_STEER_SPLIT
   } mam_steer_t;

   typedef struct packed {
      mam_op_t     op;
      logic        write;
      logic [16:0] addr;
      logic [7:0]  wdata;
   } mam_req_t;

   typedef struct packed {
      logic        iram_sel;
      logic [7:0]  iram_addr;
      logic        sfr_sel;
      logic [7:0]  sfr_addr;
      logic        bit_sel;
      logic [2:0]  bit_idx;
      logic        xram_sel;
      logic [11:0] xram_addr;
      logic        flash_sel;
      logic [15:0] flash_addr;
      logic        extra_sel;
      logic [6:0]  extra_addr;
      logic        erase_req;
      logic [6:0]  sector;
      logic        reserved_hit;
      logic        range_err;
      logic        write;
      logic [7:0]  wdata;
   } mam_dec_t;

   typedef struct packed {
      logic        ale;
      logic        rd;
      logic        wr;
      logic [7:0]  ad_out;
      logic        ad_oe;
      logic [7:0]  addr_lo;
      logic [7:0]  addr_hi;
   } mam_off_t;

endpackage : mam_pkg

// *** tb_mam_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_mam_decoder
   import mam_pkg::*;
;
   localparam int SC = 5;
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       clk_en = 1'b1;
   logic       req_valid = 1'b0;
   mam_req_t   req = '0;
   logic [1:0] reg_bank = 2'h0;
   mam_steer_t steer = MAM_STEER_ONCHIP;
   logic       muxed = 1'b0;
   logic       busy, done;
   mam_dec_t   dec;
   logic [7:0] rdata, ad_in;
   mam_off_t   off;
   int         err_total = 0;
   int         n_checks = 0;
   int         cyc = 0;
   mam_decoder #(.STROBE_CYC(SC)) i_mam_decoder (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
      .req_valid(req_valid), .req(req), .reg_bank(reg_bank), .steer(steer), .muxed(muxed), .busy(busy),
      .dec(dec), .done(done), .rdata(rdata), .off(off), .ad_in(ad_in));
   mam_offchip_mem i_mam_offchip_mem (.mclk(mclk), .off(off), .muxed(muxed), .ad_in(ad_in));
   initial forever #4 mclk = ~mclk;
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // Hang guard, well above the roughly 90 cycles needed
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic chk(input bit ok, input string m);
      n_checks++;
      if (!ok) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic go(input mam_op_t o, input logic [16:0] a);
      @(negedge mclk);
      req_valid = 1'b1;
      req = '{o, 1'b0, a, 8'h00};
      @(negedge mclk);
      req_valid = 1'b0;
   endtask : go
   task automatic xrd(input logic [16:0] a, input logic m);
      int n;
      @(negedge mclk);
      muxed = m;
      go(MAM_OP_XDATA, a);
      chk(busy === 1'b1 && dec.xram_sel === 1'b0, "not off chip");
      n = 0;
      while (done !== 1'b1 && n < 30) begin
         n++;
         @(negedge mclk);
      end
      // First look is just after the take edge, so the count is the strobe cycles plus the address cycle when muxed
      chk(n == SC + m && rdata === (a[7:0] ^ a[15:8] ^ 8'h5A), "off chip read");
   endtask : xrd
   task automatic xwr(input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      muxed = 1'b0;
      req_valid = 1'b1;
      req = '{MAM_OP_XDATA, 1'b1, {1'b0, a}, d};
      @(negedge mclk);
      req_valid = 1'b0;
      chk(off.wr === 1'b1 && off.rd === 1'b0 && off.ad_oe === 1'b1 && off.ad_out === d
          && {off.addr_hi, off.addr_lo} === a && dec.write === 1'b1, "write strobe");
      repeat (SC) @(negedge mclk);
      chk(done === 1'b1 && busy === 1'b0 && off.wr === 1'b0 && off.ad_oe === 1'b0, "write end");
   endtask : xwr
   task automatic t_freeze;
      @(negedge mclk);
      clk_en = 1'b0;
      req_valid = 1'b1;
      req = '{MAM_OP_DIRECT, 1'b0, 17'h00012, 8'h00};
      repeat (3) @(negedge mclk);
      chk(dec.iram_sel === 1'b0 && busy === 1'b0, "frozen");
      clk_en = 1'b1;
      @(negedge mclk);
      req_valid = 1'b0;
      chk(dec.iram_sel === 1'b1 && dec.iram_addr === 8'h12, "thawed");
   endtask : t_freeze
   task automatic t_reset;
      go(MAM_OP_XDATA, 17'h00033);
      @(negedge mclk);
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      chk(busy === 1'b0 && off.rd === 1'b0 && done === 1'b0, "reset mid access");
      go(MAM_OP_DIRECT, 17'h00044);
      chk(dec.iram_sel === 1'b1 && dec.iram_addr === 8'h44, "after reset");
   endtask : t_reset
   task automatic t_iram;
      go(MAM_OP_DIRECT, 17'h00035);
      chk(dec.iram_sel === 1'b1 && dec.iram_addr === 8'h35, "direct low");
      go(MAM_OP_INDIRECT, 17'h00035);
      chk(dec.iram_sel === 1'b1 && dec.iram_addr === 8'h35, "indirect low");
      go(MAM_OP_DIRECT, 17'h000B5);
      chk(dec.sfr_sel === 1'b1 && dec.iram_sel === 1'b0 && dec.sfr_addr === 8'hB5, "direct high");
      go(MAM_OP_INDIRECT, 17'h000B5);
      chk(dec.iram_sel === 1'b1 && dec.sfr_sel === 1'b0 && dec.iram_addr === 8'hB5, "indirect high");
   endtask : t_iram
   task automatic t_wreg_bit;
      for (int b = 0; b < 4; b++) begin
         @(negedge mclk);
         reg_bank = 2'(b);
         go(MAM_OP_WREG, 17'h0000F);
         chk(dec.iram_addr === 8'(b * 8 + 7), "bank");
      end
      go(MAM_OP_BIT, 17'h0007F);
      chk(dec.iram_addr === 8'h2F && dec.bit_idx === 3'h7, "bit top");
      go(MAM_OP_BIT, 17'h00000);
      chk(dec.iram_addr === 8'h20 && dec.bit_idx === 3'h0, "bit base");
      go(MAM_OP_BIT, 17'h0008D);
      chk(dec.sfr_sel === 1'b1 && dec.iram_sel === 1'b0 && dec.sfr_addr === 8'h88
          && dec.bit_idx === 3'h5, "bit upper");
   endtask : t_wreg_bit
   task automatic t_ext;
      go(MAM_OP_XDATA, 17'h0F123);
      chk(dec.xram_sel === 1'b1 && dec.xram_addr === 12'h123, "alias");
      steer = MAM_STEER_SPLIT;
      go(MAM_OP_XDATA, 17'h00FFF);
      chk(dec.xram_sel === 1'b1 && dec.xram_addr === 12'hFFF, "split low");
      xrd(17'h01000, 1'b0);
      steer = MAM_STEER_OFFCHIP;
      xrd(17'h00005, 1'b1);
      xwr(16'h4321, 8'hA5);
   endtask : t_ext
   task automatic t_code;
      go(MAM_OP_CODE_READ, 17'h0FDFF);
      chk(dec.flash_sel === 1'b1 && dec.flash_addr === 16'hFDFF, "flash");
      go(MAM_OP_CODE_ERASE, 17'h0FC00);
      chk(dec.erase_req === 1'b1 && dec.sector === 7'h7E, "erase");
      go(MAM_OP_CODE_ERASE, 17'h0FE00);
      chk(dec.reserved_hit === 1'b1 && dec.erase_req === 1'b0, "factory");
      go(MAM_OP_CODE_READ, 17'h1007F);
      chk(dec.extra_sel === 1'b1 && dec.extra_addr === 7'h7F, "extra");
      go(MAM_OP_CODE_READ, 17'h10080);
      chk(dec.range_err === 1'b1 && dec.extra_sel === 1'b0, "range");
   endtask : t_code
   initial begin
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      t_iram();
      t_freeze();
      t_wreg_bit();
      t_ext();
      t_reset();
      t_code();
      end_of_test();
   end
endmodule : tb_mam_decoder
`default_nettype wire
